// File: cstn_ctrl.sv
// Purpose: Safety timer and thermistor control/status register with timer control.
// Assumes: Byte register port with write strobe; throttle inputs are asynchronous.
// Notes: Bits 2:1 read the live thermistor fault code and ignore writes.
//
// Notes on behaviour
// - reset value 1001_1, bits 2:1 from status, bit 0 clear
// - slow bit halves timer rate
// - half rate only under listed throttle conditions
// - slow bit zero keeps normal timer rate
// - limit field selects 27m, 6h, 9h, off
// - thermistor enable bit switches monitoring
// - fault field reports thermistor band code
// - warm band lowers voltage target 140 mV
// - half-current bit halves charge current
`timescale 1ns/1ps
`default_nettype none
module cstn_ctrl #(
    parameter int TICK_CYCLES = cstn_pkg::TICK_CYCLES,
    parameter int CNT_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic i_charging,
    input wire logic i_input_current_limit,
    input wire logic i_input_voltage_regulation,
    input wire logic i_thermal_regulation,
    input wire logic i_battery_short_condition,
    input wire logic [1:0] i_thermistor_band,
    output logic o_thermistor_monitor_enable,
    output logic o_half_current_enable,
    output logic o_voltage_drop_140mv,
    output logic o_timer_expired,
    output logic o_timer_half_rate
);
    // -------------------------------------------------------------------------
    // Register bits
    // -------------------------------------------------------------------------
    logic timer_half_rate_enable_q;
    logic [1:0] limit_q;
    logic spare_q;
    logic thermistor_monitor_enable_q;
    logic half_current_enable_q;
    logic [1:0] fault_q;
    logic wr_hit;

    // Both the write decode and the read mux use this one address match.
    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == cstn_pkg::REG_ADDR);
    endfunction : reg_hit

    // The spare bit is plain storage and reads back whatever was written.
    assign wr_hit = i_ce && i_wr && reg_hit(i_addr);

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            timer_half_rate_enable_q <= cstn_pkg::RST_HALF_RATE;
            limit_q <= cstn_pkg::RST_LIMIT;
            spare_q <= cstn_pkg::RST_SPARE;
            thermistor_monitor_enable_q <= cstn_pkg::RST_THERMISTOR_MONITOR_ENABLE;
            half_current_enable_q <= cstn_pkg::RST_HALF_CUR;
        end else if (wr_hit) begin
            timer_half_rate_enable_q <= i_wdata[cstn_pkg::BIT_HALF_RATE];
            limit_q <= {i_wdata[cstn_pkg::BIT_LIMIT_HI], i_wdata[cstn_pkg::BIT_LIMIT_LO]};
            spare_q <= i_wdata[cstn_pkg::BIT_SPARE];
            thermistor_monitor_enable_q <= i_wdata[cstn_pkg::BIT_THERMISTOR_MONITOR_ENABLE];
            half_current_enable_q <= i_wdata[cstn_pkg::BIT_HALF_CUR];
        end
    end

    // -------------------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------------------
    // Stage 1 feeds only stage 2; a change is accepted once stages 2 and 3 agree.
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] clean_q;

    assign raw = {i_thermistor_band, i_battery_short_condition, i_thermal_regulation,
                  i_input_voltage_regulation, i_input_current_limit, i_charging};

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            clean_q <= '0;
        end else if (i_ce) begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int k = 0; k < NSYNC; k++) begin
                if (s2_q[k] == s3_q[k]) begin
                    clean_q[k] <= s3_q[k];
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Thermistor status and current/voltage outputs
    // -------------------------------------------------------------------------
    logic [1:0] band;
    logic charging_clean;
    logic [3:0] throttle_clean;

    // Each pin takes four enabled edges to its clean value; throttle levels move far slower.
    assign band = clean_q[6:5];
    assign charging_clean = clean_q[0];
    assign throttle_clean = clean_q[4:1];

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            fault_q <= cstn_pkg::TS_NORMAL;
            o_voltage_drop_140mv <= 1'b0;
            o_half_current_enable <= 1'b0;
            o_thermistor_monitor_enable <= 1'b0;
        end else if (i_ce) begin
            // Monitoring off reports normal so a stale band cannot throttle charging.
            fault_q <= thermistor_monitor_enable_q ? band : cstn_pkg::TS_NORMAL;
            o_voltage_drop_140mv <= (fault_q == cstn_pkg::TS_WARM);
            o_half_current_enable <= half_current_enable_q;
            o_thermistor_monitor_enable <= thermistor_monitor_enable_q;
        end
    end

    // -------------------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            // Bits 2:1 carry the live fault code, so writes to them are dropped.
            if (reg_hit(i_addr)) begin
                o_rdata <= {timer_half_rate_enable_q, limit_q, spare_q,
                            thermistor_monitor_enable_q, fault_q, half_current_enable_q};
            end else begin
                // Unmapped addresses read as zero so a probe cannot alias this register.
                o_rdata <= 8'h00;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Safety timer control
    // -------------------------------------------------------------------------
    function automatic logic [CNT_W-1:0] limit_ticks(input logic [1:0] code);
        case (code)
            cstn_pkg::LIM_27MIN: limit_ticks = CNT_W'(cstn_pkg::LIMIT_27_MIN * cstn_pkg::TICKS_PER_MIN);
            cstn_pkg::LIM_6H: limit_ticks = CNT_W'(cstn_pkg::LIMIT_6_HOUR_MIN * cstn_pkg::TICKS_PER_MIN);
            cstn_pkg::LIM_9H: limit_ticks = CNT_W'(cstn_pkg::LIMIT_9_HOUR_MIN * cstn_pkg::TICKS_PER_MIN);
            default: limit_ticks = '0;
        endcase
    endfunction : limit_ticks

    logic [31:0] pre_q;
    logic step;
    logic throttled;
    logic half;
    logic run;
    logic expired;
    logic [CNT_W-1:0] limit_cnt;

    assign step = (pre_q == 32'(TICK_CYCLES - 1));

    // The prescaler runs freely, so the first tick after a start can come up to one
    // tick early; against limits of many minutes that error is negligible.
    // It wraps only on an enabled edge, so a low enable holds its phase.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pre_q <= '0;
        end else if (i_ce) begin
            if (step) begin
                pre_q <= '0;
            end else begin
                pre_q <= pre_q + 32'h1;
            end
        end
    end

    assign throttled = (|throttle_clean)
                       || half_current_enable_q || (fault_q == cstn_pkg::TS_COOL);
    assign half = timer_half_rate_enable_q && throttled;
    assign run = charging_clean && (limit_q != cstn_pkg::LIM_OFF);
    assign limit_cnt = limit_ticks(limit_q);

    cstn_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_run(run),
        .i_step(step && i_ce),
        .i_half(half),
        .i_limit(limit_cnt),
        .o_expired(expired)
    );

    // -------------------------------------------------------------------------
    // Registered timer outputs
    // -------------------------------------------------------------------------
    // These sit one edge behind the timer so every output leaves a flip-flop.
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_timer_expired <= 1'b0;
            o_timer_half_rate <= 1'b0;
        end else if (i_ce) begin
            o_timer_expired <= expired;
            o_timer_half_rate <= half;
        end
    end
endmodule : cstn_ctrl
`default_nettype wire

// File: cstn_pkg.sv
// Purpose: Shared constants for the charge safety timer and thermistor control register.
// Assumes: 25 MHz system clock; byte-wide register access port.
// Notes: Timer limits are held in minutes and converted to base ticks by the register block.
package cstn_pkg;
    // -------------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------------
    localparam logic [7:0] REG_ADDR = 8'h07;
    localparam int BIT_HALF_RATE = 7;
    localparam int BIT_LIMIT_HI = 6;
    localparam int BIT_LIMIT_LO = 5;
    localparam int BIT_SPARE = 4;
    localparam int BIT_THERMISTOR_MONITOR_ENABLE = 3;
    localparam int BIT_FAULT_HI = 2;
    localparam int BIT_FAULT_LO = 1;
    localparam int BIT_HALF_CUR = 0;
    localparam logic RST_HALF_RATE = 1'b1;
    localparam logic [1:0] RST_LIMIT = 2'h0;
    localparam logic RST_SPARE = 1'b1;
    localparam logic RST_THERMISTOR_MONITOR_ENABLE = 1'b1;
    localparam logic RST_HALF_CUR = 1'b0;

    // -------------------------------------------------------------------------
    // Time limit codes and values
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        LIM_27MIN = 2'h0,
        LIM_6H = 2'h1,
        LIM_9H = 2'h2,
        LIM_OFF = 2'h3
    } cstn_limit_t;
    localparam int LIMIT_27_MIN = 27;
    localparam int LIMIT_6_HOUR_MIN = 360;
    localparam int LIMIT_9_HOUR_MIN = 540;

    // Thermistor fault codes.
    localparam logic [1:0] TS_NORMAL = 2'h0;
    localparam logic [1:0] TS_SUSPEND = 2'h1;
    localparam logic [1:0] TS_COOL = 2'h2;
    localparam logic [1:0] TS_WARM = 2'h3;
    localparam int WARM_DROP_MV = 140;

    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int TICK_US = 1000000;
    localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
    localparam int TICKS_PER_MIN = 60;
    localparam int SYNC_STAGES = 3;
endpackage : cstn_pkg

// File: cstn_timer.sv
// Purpose: Fast-charge safety timer counting base ticks up to a limit.
// Assumes: Tick is a one-cycle pulse; enable gates both tick and state.
// Notes: Count width fits 540 minutes of one-second ticks.
`timescale 1ns/1ps
`default_nettype none
module cstn_timer #(
    parameter int CNT_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_run,
    input wire logic i_step,
    input wire logic i_half,
    input wire logic [CNT_W-1:0] i_limit,
    output logic o_expired
);
    logic [CNT_W-1:0] count_q;
    logic phase_q;
    logic advance;

    // Half rate lets only every other tick through.
    assign advance = i_step && (!i_half || phase_q);

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            phase_q <= 1'b0;
        end else if (i_ce) begin
            if (!i_run) begin
                phase_q <= 1'b0;
            end else if (i_step && i_half) begin
                phase_q <= !phase_q;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            count_q <= '0;
            o_expired <= 1'b0;
        end else if (i_ce && !i_run) begin
            count_q <= '0;
            o_expired <= 1'b0;
        end else if (i_ce) begin
            if (advance && count_q < i_limit) begin
                count_q <= count_q + 1'b1;
            end
            o_expired <= (count_q >= i_limit);
        end
    end
endmodule : cstn_timer
`default_nettype wire

// File: cstn_ctrl_sva.sv
// Purpose: Port checker for the timer and thermistor register.
// Assumes: Async inputs reach the outputs within six cycles.
// Notes: Bound into every instance of the register block.
`timescale 1ns/1ps
`default_nettype none
module cstn_ctrl_sva #(
    parameter int TICK_CYCLES = 1,
    parameter int CNT_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic i_charging,
    input wire logic i_input_current_limit,
    input wire logic i_input_voltage_regulation,
    input wire logic i_thermal_regulation,
    input wire logic i_battery_short_condition,
    input wire logic [1:0] i_thermistor_band,
    input wire logic o_thermistor_monitor_enable,
    input wire logic o_half_current_enable,
    input wire logic o_voltage_drop_140mv,
    input wire logic o_timer_expired,
    input wire logic o_timer_half_rate
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    logic quiet;
    assign quiet = !(i_input_current_limit | i_input_voltage_regulation | i_thermal_regulation
        | i_battery_short_condition | o_half_current_enable) && i_thermistor_band != 2'h2;
    unmapped_read_a: assert property ($past(i_ce) && $past(i_addr) != 8'h07 |->
        o_rdata == 8'h00) else $error("unmapped read not zero");
    read_mirror_a: assert property ($past(i_ce) && $past(i_addr) == 8'h07 |->
        o_rdata[3] == o_thermistor_monitor_enable && o_rdata[0] == o_half_current_enable)
        else $error("read byte disagrees with outputs");
    write_lands_a: assert property (i_ce && i_wr && i_addr == 8'h07 ##1 i_ce |=>
        ($past(i_wdata, 2) & 8'h09) == {4'h0, o_thermistor_monitor_enable, 2'h0,
        o_half_current_enable}) else $error("written bits not on outputs");
    monitor_off_a: assert property (!o_thermistor_monitor_enable [*3] |->
        !o_voltage_drop_140mv) else $error("drop while monitoring off");
    warm_drop_a: assert property ((i_thermistor_band == 2'h3 && o_thermistor_monitor_enable)
        [*8] |-> o_voltage_drop_140mv) else $error("warm band without drop");
    not_warm_a: assert property (i_thermistor_band != 2'h3 [*8] |->
        !o_voltage_drop_140mv) else $error("drop outside warm band");
    stop_clears_a: assert property (!i_charging [*8] |-> !o_timer_expired)
        else $error("expired while not charging");
    no_slow_a: assert property (quiet [*8] |-> !o_timer_half_rate)
        else $error("timer slowed without throttle");
    cover property (o_timer_expired);
    cover property (o_timer_half_rate);
    cover property (o_voltage_drop_140mv);
endmodule : cstn_ctrl_sva
bind cstn_ctrl cstn_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES), .CNT_W(CNT_W)) u_sva (.*);
`default_nettype wire

// File: cstn_host.sv
// Purpose: Host model that drives the byte register port.
// Assumes: Requests change only at the falling edge.
// Notes: Released write data is inverted so stale values never match.
`timescale 1ns/1ps
`default_nettype none
module cstn_host (
    input wire logic i_clk_sys,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata
);
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
    end
    // Every charge setting, half current included, is a register write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk_sys);
        o_wr = 1'b0;
        o_wdata = ~d;
    endtask : wr
    task automatic point(input logic [7:0] a);
        @(negedge i_clk_sys);
        o_addr = a;
    endtask : point
endmodule : cstn_host
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the timer and thermistor register.
// Assumes: Two-cycle tick, so the shortest limit is 3240 cycles.
// Notes: Longer limits are only checked not to expire early.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int TC = 2;
    localparam int LIM = 27 * 60 * TC;
    logic i_clk_sys = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_charging = 1'b0, i_wr;
    logic [3:0] thr = 4'h0;
    logic [1:0] i_thermistor_band = 2'h0, take = 2'h0;
    logic [7:0] i_addr, i_wdata, o_rdata, m;
    logic o_thermistor_monitor_enable, o_half_current_enable;
    logic o_voltage_drop_140mv, o_timer_expired, o_timer_half_rate;
    logic [31:0] seed = 32'h0b7c;
    logic [7:0] exp_q[$];
    int n_fail = 0, checks = 0, b, r;
    always #20 i_clk_sys = ~i_clk_sys;
    cstn_host u_host (.i_clk_sys, .o_addr(i_addr), .o_wr(i_wr), .o_wdata(i_wdata));
    cstn_ctrl #(.TICK_CYCLES(TC), .CNT_W(16)) u_dut (.*, .i_input_current_limit(thr[0]),
        .i_input_voltage_regulation(thr[1]), .i_thermal_regulation(thr[2]),
        .i_battery_short_condition(thr[3]));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    // Kind 1 compares the read byte, kind 2 the packed output flags.
    task automatic expect_v(input logic [1:0] kind, input logic [7:0] v);
        @(negedge i_clk_sys);
        exp_q.push_back(v);
        take = kind;
        @(negedge i_clk_sys);
        take = 2'h0;
    endtask : expect_v
    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        u_host.point(a);
        expect_v(2'h1, v);
    endtask : rd
    task automatic timed(input int n, input logic [7:0] s, input logic fires);
        i_charging = 1'b1;
        repeat (n - 16) @(negedge i_clk_sys);
        expect_v(2'h2, s);
        repeat (28) @(negedge i_clk_sys);
        expect_v(2'h2, s | {4'h0, fires, 3'h0});
        i_charging = 1'b0;
        repeat (12) @(negedge i_clk_sys);
    endtask : timed
    always @(posedge i_clk_sys) begin
        if (take != 2'h0) begin
            check(take == 2'h1 ? o_rdata : {3'h0, o_timer_half_rate, o_timer_expired,
                o_voltage_drop_140mv, o_half_current_enable, o_thermistor_monitor_enable},
                exp_q.pop_front());
        end
    end
    initial begin
        repeat (60000) @(posedge i_clk_sys);
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (12) @(negedge i_clk_sys);
        i_srst = 1'b0;
        rd(8'h07, 8'h98);
        expect_v(2'h2, 8'h01);
        $display("reset test done");
        m = 8'h98;
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            if (seed[0]) begin
                u_host.wr(8'h07, seed[15:8] & 8'h7f);
                m = seed[15:8] & 8'h79;
            end else begin
                u_host.wr({seed[23:17], 1'b0}, seed[15:8]);
            end
            rd(8'h07, m);
            rd({seed[31:25], 1'b0}, 8'h00);
            expect_v(2'h2, {6'h0, m[0], m[3]});
        end
        // A write with the clock enable low must leave the register alone.
        i_ce = 1'b0;
        u_host.wr(8'h07, ~m);
        i_ce = 1'b1;
        rd(8'h07, m);
        $display("register test done");
        u_host.wr(8'h07, 8'h08);
        for (b = 0; b < 4; b++) begin
            i_thermistor_band = b[1:0];
            repeat (10) @(negedge i_clk_sys);
            rd(8'h07, {5'h01, b[1:0], 1'b0});
            expect_v(2'h2, {5'h0, b == 3, 2'h1});
        end
        u_host.wr(8'h07, 8'h00);
        repeat (4) @(negedge i_clk_sys);
        rd(8'h07, 8'h00);
        expect_v(2'h2, 8'h00);
        $display("thermistor test done");
        i_charging = 1'b1;
        for (b = 0; b < 6; b++) begin
            thr = (b < 4) ? 4'h1 << b : 4'h0;
            i_thermistor_band = (b == 5) ? 2'h2 : 2'h0;
            for (r = 1; r >= 0; r--) begin
                u_host.wr(8'h07, {r[0], 7'h28} | {7'h0, b == 4});
                repeat (10) @(negedge i_clk_sys);
                expect_v(2'h2, {3'h0, r[0], 2'h0, b == 4, 1'b1});
            end
        end
        thr = 4'h0;
        i_thermistor_band = 2'h0;
        u_host.wr(8'h07, 8'ha8);
        repeat (10) @(negedge i_clk_sys);
        expect_v(2'h2, 8'h01);
        $display("throttle test done");
        i_charging = 1'b0;
        thr = 4'h4;
        repeat (12) @(negedge i_clk_sys);
        for (b = 0; b < 4; b++) begin
            u_host.wr(8'h07, {1'b0, b[1:0], 5'h08});
            timed(LIM, 8'h01, b == 0);
        end
        u_host.wr(8'h07, 8'h88);
        timed(2 * LIM, 8'h11, 1'b1);
        $display("timer test done");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
